/* rtl/xma_media_alu.v */
// Packed media ALU: eight 64-bit packed registers, extended instruction
// execution and an AHB-Lite register slave.
// Assumes the instruction decoder runs on hclk and holds a request until
// it is taken; the memory operand arrives with the request.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "xma_defs.vh"

module xma_media_alu (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire ins_valid,
   input wire [7:0] ins_opcode,
   input wire [7:0] ins_modrm,
   input wire [63:0] ins_mem_data,
   output reg ins_ready_q,
   output reg ins_done_q,
   output reg ins_fault_q
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   reg [63:0] preg_q [0:7];
   reg [7:0] extension_config_control_q;
   reg fault_seen_q;
   reg busy_q;
   reg [1:0] cnt_q;
   reg [2:0] op_q;
   reg [2:0] dst_q;
   reg [63:0] opa_q;
   reg [63:0] opb_q;
   reg [63:0] opc_q;
   reg wr_pend_q;
   reg [9:0] wr_idx_q;
   reg wr_ok_q;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire ext_en = extension_config_control_q[`XMA_CFG_EN_BIT];
   wire reg_form = (ins_modrm[7:6] == `XMA_MODE_REG);
   wire [2:0] packed_dest_register = ins_modrm[5:3];
   wire [2:0] packed_source_register = ins_modrm[2:0];
   // Paired registers are each other's implied target
   wire [2:0] implied_reg = {packed_dest_register[2:1], ~packed_dest_register[0]};
   wire take = ins_valid && ins_ready_q;

   reg dec_ok;
   reg dec_ext;
   reg dec_implied;
   reg [2:0] dec_op;
   reg [1:0] dec_lat;

   always @* begin
      dec_ok = 1'b1;
      dec_ext = 1'b1;
      dec_implied = 1'b0;
      dec_op = `XMA_OP_ADDSI;
      dec_lat = `XMA_LAT_ONE;
      case (ins_opcode)
         `XMA_OPC_ADDSI: begin
            dec_implied = 1'b1;
         end
         `XMA_OPC_AVG: begin
            dec_op = `XMA_OP_AVG;
         end
         `XMA_OPC_DIST: begin
            // Register form has no encoding here
            dec_ok = !reg_form;
            dec_implied = 1'b1;
            dec_op = `XMA_OP_DIST;
            dec_lat = `XMA_LAT_TWO;
         end
         `XMA_OPC_MAC: begin
            dec_ok = !reg_form;
            dec_implied = 1'b1;
            dec_op = `XMA_OP_MAC;
            dec_lat = `XMA_LAT_TWO;
         end
         `XMA_OPC_MAG: begin
            dec_op = `XMA_OP_MAG;
            dec_lat = `XMA_LAT_TWO;
         end
         `XMA_OPC_PACKWB: begin
            dec_ext = 1'b0;
            dec_op = `XMA_OP_PACKWB;
         end
         `XMA_OPC_PACKDW: begin
            dec_ext = 1'b0;
            dec_op = `XMA_OP_PACKDW;
         end
         default: begin
            dec_ok = 1'b0;
            dec_ext = 1'b0;
         end
      endcase
      // Extended opcodes are illegal while the enable is clear
      if (dec_ext && !ext_en) begin
         dec_ok = 1'b0;
      end
   end

   // Source operand: register in mode 11, otherwise the fetched memory word
   wire [63:0] src_val = reg_form ? preg_q[packed_source_register] : ins_mem_data;

   // ---------------------------------------------------------------
   // Execution sequencer
   // ---------------------------------------------------------------
   wire [63:0] alu_res;
   wire exec_wr = busy_q && (cnt_q == 2'h0);

   xma_lane_alu u_lane_alu (
      .op(op_q),
      .opa(opa_q),
      .opb(opb_q),
      .opc(opc_q),
      .res(alu_res)
   );

   // Operands are frozen at issue so later writes cannot disturb them
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         cnt_q <= 2'h0;
         op_q <= `XMA_OP_ADDSI;
         dst_q <= 3'h0;
         opa_q <= 64'h0000000000000000;
         opb_q <= 64'h0000000000000000;
         opc_q <= 64'h0000000000000000;
         ins_ready_q <= 1'b0;
         ins_done_q <= 1'b0;
         ins_fault_q <= 1'b0;
      end else begin
         ins_done_q <= exec_wr;
         ins_fault_q <= take && !dec_ok;
         if (take && dec_ok) begin
            busy_q <= 1'b1;
            cnt_q <= dec_lat;
            op_q <= dec_op;
            dst_q <= dec_implied ? implied_reg : packed_dest_register;
            opa_q <= preg_q[packed_dest_register];
            opb_q <= src_val;
            opc_q <= preg_q[implied_reg];
            ins_ready_q <= 1'b0;
         end else if (exec_wr) begin
            busy_q <= 1'b0;
            ins_ready_q <= 1'b1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 2'h1;
         end else begin
            ins_ready_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   // Zero wait states: read data is prepared in the address phase.
   wire addr_ok = (haddr[31:12] == 20'h00000);
   wire [9:0] a_idx = haddr[11:2];
   wire a_phase = hsel && htrans[1] && hready;

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (addr_ok) begin
         if ({haddr[11:2], 2'b00} <= `XMA_PREG_LAST) begin
            rd_mux = haddr[2] ? preg_q[haddr[5:3]][63:32] : preg_q[haddr[5:3]][31:0];
         end else if (a_idx == `XMA_CFG_INDEX) begin
            rd_mux = {24'h000000, extension_config_control_q};
         end else if ({haddr[11:2], 2'b00} == `XMA_STATUS_ADDR) begin
            rd_mux = {30'h00000000, fault_seen_q, busy_q};
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_idx_q <= 10'h000;
         wr_ok_q <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= a_phase && hwrite;
         if (a_phase) begin
            wr_idx_q <= a_idx;
            wr_ok_q <= addr_ok;
            hrdata <= hwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

   wire bus_wr = wr_pend_q && wr_ok_q;

   // ---------------------------------------------------------------
   // Configuration and status
   // ---------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         extension_config_control_q <= `XMA_CFG_RESET;
         fault_seen_q <= 1'b0;
      end else begin
         if (bus_wr && wr_idx_q == `XMA_CFG_INDEX) begin
            extension_config_control_q <= hwdata[7:0];
         end
         // A new fault wins over a write-one clear in the same cycle
         if (take && !dec_ok) begin
            fault_seen_q <= 1'b1;
         end else if (bus_wr && {wr_idx_q, 2'b00} == `XMA_STATUS_ADDR &&
               hwdata[`XMA_ST_FAULT_BIT]) begin
            fault_seen_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Packed register file
   // ---------------------------------------------------------------
   // Execution write-back has priority over a bus write to the same word.
   genvar r;
   generate
      for (r = 0; r < 8; r = r + 1) begin : g_preg
         wire bus_hit = bus_wr && (wr_idx_q[9:4] == 6'h00) && (wr_idx_q[3:1] == r);
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               preg_q[r] <= 64'h0000000000000000;
            end else if (exec_wr && dst_q == r) begin
               preg_q[r] <= alu_res;
            end else if (bus_hit && wr_idx_q[0]) begin
               preg_q[r][63:32] <= hwdata;
            end else if (bus_hit) begin
               preg_q[r][31:0] <= hwdata;
            end
         end
      end
   endgenerate

endmodule // xma_media_alu

/* rtl/xma_defs.vh */
// Constants for the packed media ALU: register map, field positions, reset
// values, internal operation codes and execution latencies.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef XMA_DEFS_VH
`define XMA_DEFS_VH

// ---------------------------------------------------------------
// Register map (byte addresses on the bus; XMA_CFG_INDEX is a word index)
// ---------------------------------------------------------------
`define XMA_CFG_INDEX 10'h0eb
`define XMA_CFG_ADDR 12'h3ac
`define XMA_PREG_BASE 12'h000
`define XMA_PREG_LAST 12'h03c
`define XMA_STATUS_ADDR 12'h040
`define XMA_CFG_RESET 8'h00
`define XMA_CFG_EN_BIT 0
`define XMA_ST_BUSY_BIT 0
`define XMA_ST_FAULT_BIT 1

// ---------------------------------------------------------------
// Instruction encoding
// ---------------------------------------------------------------
`define XMA_OPC_AVG 8'h50
`define XMA_OPC_ADDSI 8'h51
`define XMA_OPC_MAG 8'h52
`define XMA_OPC_DIST 8'h54
`define XMA_OPC_MAC 8'h5e
`define XMA_OPC_PACKWB 8'h63
`define XMA_OPC_PACKDW 8'h6b
`define XMA_MODE_REG 2'b11

// ---------------------------------------------------------------
// Internal operation select and latency
// ---------------------------------------------------------------
`define XMA_OP_ADDSI 3'h0
`define XMA_OP_AVG 3'h1
`define XMA_OP_DIST 3'h2
`define XMA_OP_MAC 3'h3
`define XMA_OP_MAG 3'h4
`define XMA_OP_PACKWB 3'h5
`define XMA_OP_PACKDW 3'h6
`define XMA_LAT_ONE 2'h0
`define XMA_LAT_TWO 2'h1
`define XMA_MAC_ROUND 32'h00004000

`endif

/* rtl/xma_lane_alu.v */
// Combinational lane arithmetic for the packed media ALU.
// Assumes operands are stable registers; result is captured by the caller.
`timescale 1ns/1ps
`include "xma_defs.vh"

module xma_lane_alu (
   input wire [2:0] op,
   input wire [63:0] opa,
   input wire [63:0] opb,
   input wire [63:0] opc,
   output reg [63:0] res
);
   wire [63:0] r_add;
   wire [63:0] r_avg;
   wire [63:0] r_dist;
   wire [63:0] r_mac;
   wire [63:0] r_mag;
   wire [63:0] r_pwb;
   wire [63:0] r_pdw;

   // ---------------------------------------------------------------
   // Word lanes, each holding two byte lanes
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_word
         wire [15:0] aw = opa[16*i +: 16];
         wire [15:0] bw = opb[16*i +: 16];
         wire [15:0] cw = opc[16*i +: 16];
         // Top bit of each lane is its sign
         wire [16:0] sum = {aw[15], aw} + {bw[15], bw};
         wire [16:0] mag_a = aw[15] ? (17'h00000 - {aw[15], aw}) : {1'b0, aw};
         wire [16:0] mag_b = bw[15] ? (17'h00000 - {bw[15], bw}) : {1'b0, bw};
         wire signed [31:0] prod = $signed(aw) * $signed(bw);
         wire [31:0] prod_r = prod + `XMA_MAC_ROUND;
         // Clamp on overflow instead of wrapping
         assign r_add[16*i +: 16] = (sum[16] != sum[15]) ?
            (sum[16] ? 16'h8000 : 16'h7fff) : sum[15:0];
         // Larger magnitude wins, ties keep the destination word
         assign r_mag[16*i +: 16] = (mag_b > mag_a) ? bw : aw;
         // Rounded product half accumulated into the implied word
         assign r_mac[16*i +: 16] = cw + prod_r[30:15];
         // Narrow words to bytes with signed saturation
         assign r_pwb[8*i +: 8] = (aw[15] && aw[15:7] != 9'h1ff) ? 8'h80 :
            (!aw[15] && aw[15:7] != 9'h000) ? 8'h7f : aw[7:0];
         assign r_pwb[32+8*i +: 8] = (bw[15] && bw[15:7] != 9'h1ff) ? 8'h80 :
            (!bw[15] && bw[15:7] != 9'h000) ? 8'h7f : bw[7:0];
         genvar j;
         for (j = 0; j < 2; j = j + 1) begin : g_byte
            wire [7:0] ab = aw[8*j +: 8];
            wire [7:0] bb = bw[8*j +: 8];
            wire [7:0] cb = cw[8*j +: 8];
            wire [8:0] avg = {1'b0, ab} + {1'b0, bb} + 9'h001;
            wire [7:0] dif = (ab > bb) ? (ab - bb) : (bb - ab);
            wire [8:0] acc = {1'b0, cb} + {1'b0, dif};
            assign r_avg[16*i+8*j +: 8] = avg[8:1];
            assign r_dist[16*i+8*j +: 8] = acc[8] ? 8'hff : acc[7:0];
         end
      end
      // Doublewords narrow to words; destination fills the low half
      for (i = 0; i < 2; i = i + 1) begin : g_dword
         wire [31:0] ad = opa[32*i +: 32];
         wire [31:0] bd = opb[32*i +: 32];
         assign r_pdw[16*i +: 16] = (ad[31] && ad[31:15] != 17'h1ffff) ? 16'h8000 :
            (!ad[31] && ad[31:15] != 17'h00000) ? 16'h7fff : ad[15:0];
         assign r_pdw[32+16*i +: 16] = (bd[31] && bd[31:15] != 17'h1ffff) ? 16'h8000 :
            (!bd[31] && bd[31:15] != 17'h00000) ? 16'h7fff : bd[15:0];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Result select
   // ---------------------------------------------------------------
   always @* begin
      case (op)
         `XMA_OP_ADDSI: res = r_add;
         `XMA_OP_AVG: res = r_avg;
         `XMA_OP_DIST: res = r_dist;
         `XMA_OP_MAC: res = r_mac;
         `XMA_OP_MAG: res = r_mag;
         `XMA_OP_PACKWB: res = r_pwb;
         `XMA_OP_PACKDW: res = r_pdw;
         default: res = 64'h0000000000000000;
      endcase
   end
endmodule // xma_lane_alu

/* verif/xma_alu_checker.sv */
// Concurrent checks on the instruction port of the packed media ALU.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/1ps
`include "xma_defs.vh"

module xma_alu_checker (
   input wire hclk,
   input wire hresetn,
   input wire ins_valid,
   input wire [7:0] ins_opcode,
   input wire [7:0] ins_modrm,
   input wire ins_ready_q,
   input wire ins_done_q,
   input wire ins_fault_q
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   wire op_one = ins_opcode == `XMA_OPC_AVG || ins_opcode == `XMA_OPC_ADDSI;
   wire op_mem = ins_opcode == `XMA_OPC_DIST || ins_opcode == `XMA_OPC_MAC;
   wire op_two = op_mem || ins_opcode == `XMA_OPC_MAG;
   wire op_pk = ins_opcode == `XMA_OPC_PACKWB || ins_opcode == `XMA_OPC_PACKDW;
   wire reg_form = ins_modrm[7:6] == `XMA_MODE_REG;
   sequence s_take;
      ins_valid && ins_ready_q;
   endsequence
   // Enable state is invisible here, so latency is judged only on accepted ops
   sequence s_one;
      s_take ##0 op_one ##1 !ins_fault_q;
   endsequence
   sequence s_two;
      s_take ##0 op_two ##1 !ins_fault_q;
   endsequence
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_one_clock: assert property (s_one |=> ins_done_q)
      else $error("one clock op late");
   a_two_clock: assert property (s_two |=> !ins_done_q ##1 ins_done_q)
      else $error("two clock op timing wrong");
   a_take_result: assert property (s_take |=> ins_ready_q == ins_fault_q)
      else $error("ready and fault disagree");
   a_unknown_fault: assert property (s_take ##0 !(op_two || op_one || op_pk) |=> ins_fault_q)
      else $error("unknown opcode accepted");
   a_memonly_fault: assert property (s_take ##0 (op_mem && reg_form) |=> ins_fault_q)
      else $error("register form of memory only op accepted");
   a_done_busy: assert property (ins_done_q |-> ins_ready_q && !$past(ins_ready_q))
      else $error("done without busy period");
   a_fault_clean: assert property (ins_fault_q |-> ins_ready_q && !ins_done_q)
      else $error("fault with write back");
   a_busy_bound: assert property ($fell(ins_ready_q) |=> ##[0:1] ins_ready_q)
      else $error("busy too long");
endmodule // xma_alu_checker

/* verif/xma_core_model.sv */
// Decoder side model: presents one instruction and holds it until taken.
// Assumes issue is called just after a rising edge of hclk.
`timescale 1ns/1ps

module xma_core_model (
   input wire hclk,
   input wire ins_ready_q,
   output reg ins_valid,
   output reg [7:0] ins_opcode,
   output reg [7:0] ins_modrm,
   output reg [63:0] ins_mem_data
);
   initial begin
      ins_valid = 1'b0;
      ins_opcode = 8'h00;
      ins_modrm = 8'h00;
      ins_mem_data = 64'h0;
   end
   // Released lines show the inverse, so stale operands cannot look live
   task issue(input [7:0] op, input [7:0] m, input [63:0] mem);
      begin
         ins_valid <= 1'b1;
         ins_opcode <= op;
         ins_modrm <= m;
         ins_mem_data <= mem;
         @(posedge hclk);
         while (!ins_ready_q) @(posedge hclk);
         ins_valid <= 1'b0;
         ins_opcode <= ~op;
         ins_modrm <= ~m;
         ins_mem_data <= ~mem;
      end
   endtask
endmodule // xma_core_model

/* verif/xma_media_alu_tb_top.sv */
// Bench for the packed media ALU: AHB-Lite register access and instructions.
// Assumes one slave on the bus, so hready is the slave's hreadyout.
`timescale 1ns/1ps
`include "xma_defs.vh"

module xma_media_alu_tb_top;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'b00;
   reg hwrite = 1'b0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h0;
   reg [31:0] r;
   wire [31:0] hrdata;
   wire hreadyout, hresp, ins_valid, ins_ready_q, ins_done_q, ins_fault_q;
   wire [7:0] ins_opcode, ins_modrm;
   wire [63:0] ins_mem_data;
   integer n_fail = 0;
   integer checks = 0;
   integer cyc = 0;
   always #20 hclk = ~hclk;
   xma_media_alu u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ins_valid(ins_valid),
      .ins_opcode(ins_opcode), .ins_modrm(ins_modrm), .ins_mem_data(ins_mem_data),
      .ins_ready_q(ins_ready_q), .ins_done_q(ins_done_q), .ins_fault_q(ins_fault_q));
   xma_core_model u_core (.hclk(hclk), .ins_ready_q(ins_ready_q), .ins_valid(ins_valid),
      .ins_opcode(ins_opcode), .ins_modrm(ins_modrm), .ins_mem_data(ins_mem_data));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task wrap_up;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [63:0] seen, input [63:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task bus(input w, input [31:0] a, input [31:0] d, output [31:0] q);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= a;
         hwrite <= w;
         @(posedge hclk);
         while (!hreadyout) @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         @(posedge hclk);
         while (!hreadyout) @(posedge hclk);
         q = hrdata;
         // Every single word transfer must answer OKAY with no wait state left
         chk({hresp, hreadyout}, 64'h1);
      end
   endtask
   task wq(input [31:0] n, input [63:0] v);
      begin
         bus(1'b1, 8 * n, v[31:0], r);
         bus(1'b1, 8 * n + 4, v[63:32], r);
      end
   endtask
   task rq(input [31:0] n, input [63:0] exp);
      reg [31:0] lo, hi;
      begin
         bus(1'b0, 8 * n, 32'h0, lo);
         bus(1'b0, 8 * n + 4, 32'h0, hi);
         chk({hi, lo}, exp);
      end
   endtask
   // Expects {done, fault}; the wait is bounded by a few cycles
   task run(input [7:0] op, input [7:0] m, input [63:0] mem, input [1:0] e);
      integer k;
      begin
         u_core.issue(op, m, mem);
         k = 0;
         while (k < 4 && !(ins_done_q || ins_fault_q)) begin
            @(posedge hclk);
            k = k + 1;
         end
         chk({ins_done_q, ins_fault_q}, e);
      end
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail = n_fail + 1;
         wrap_up;
      end
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, `XMA_CFG_ADDR, 32'h0, r);
      chk(r, 0);
      bus(1'b0, 32'h100, 32'h0, r);
      chk(r, 0);
      rq(0, 0);
      wq(0, 64'hfffe_0001_8000_7fff);
      wq(2, 64'hfffe_0002_ffff_0001);
      run(`XMA_OPC_ADDSI, 8'hd0, 64'h0, 2'b01);
      rq(3, 0);
      bus(1'b1, `XMA_CFG_ADDR, 32'h1, r);
      bus(1'b0, `XMA_CFG_ADDR, 32'h0, r);
      chk(r, 1);
      run(`XMA_OPC_ADDSI, 8'hd0, 64'h0, 2'b10);
      rq(3, 64'hfffc_0003_8000_7fff);
      rq(0, 64'hfffe_0001_8000_7fff);
      rq(2, 64'hfffe_0002_ffff_0001);
      run(`XMA_OPC_ADDSI, 8'hd8, 64'h0, 2'b10);
      rq(2, 64'hfffa_0004_8000_7fff);
      run(`XMA_OPC_AVG, 8'h08, 64'h01ff_0203_0000_fe80, 2'b10);
      rq(1, 64'h0180_0102_0000_7f40);
      run(`XMA_OPC_DIST, 8'hc0, 64'h0, 2'b01);
      run(`XMA_OPC_DIST, 8'h00, 64'h00ff_0101_0080_ff00, 2'b10);
      rq(1, 64'hff81_0202_8080_ffff);
      run(`XMA_OPC_MAC, 8'h10, 64'h0000_4000_0000_8000, 2'b10);
      rq(3, 64'hfffc_0005_8000_0000);
      run(`XMA_OPC_MAG, 8'hc2, 64'h0, 2'b10);
      rq(0, 64'hfffa_0004_8000_7fff);
      run(`XMA_OPC_MAG, 8'h00, 64'h0005_fff0_7fff_8001, 2'b10);
      rq(0, 64'hfffa_fff0_8000_7fff);
      run(`XMA_OPC_PACKWB, 8'hc9, 64'h0, 2'b10);
      rq(1, 64'h817f_80ff_817f_80ff);
      run(8'h99, 8'hc0, 64'h0, 2'b01);
      bus(1'b0, `XMA_STATUS_ADDR, 32'h0, r);
      chk(r, 64'h2);
      bus(1'b1, `XMA_STATUS_ADDR, 32'h2, r);
      bus(1'b0, `XMA_STATUS_ADDR, 32'h0, r);
      chk(r, 64'h0);
      wq(4, 64'h0000_7fff_ffff_8000);
      wq(5, 64'h8000_0000_0001_2345);
      run(`XMA_OPC_PACKDW, 8'he5, 64'h0, 2'b10);
      rq(4, 64'h8000_7fff_7fff_8000);
      rq(5, 64'h8000_0000_0001_2345);
      wrap_up;
   end
endmodule // xma_media_alu_tb_top

bind xma_media_alu xma_alu_checker u_chk (.hclk(hclk), .hresetn(hresetn),
   .ins_valid(ins_valid), .ins_opcode(ins_opcode), .ins_modrm(ins_modrm),
   .ins_ready_q(ins_ready_q), .ins_done_q(ins_done_q), .ins_fault_q(ins_fault_q));
